// file: core/rps_status_bank.sv
// per-receive-port link status register bank, read through a port-select window
`timescale 1ns/10ps
module rps_status_bank
#(
   parameter int NP = 4,
   parameter int SELW = 2
)
(
   // clocks and reset
   input wire logic clk,
   input wire logic link_clk,
   input wire logic rst_n,
   // register access from the control port slave
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // receiver events, one pulse per port, link_clk domain
   input wire logic [NP-1:0] lk_line_length_unsteady,
   input wire logic [NP-1:0] lk_line_length_changed,
   input wire logic [NP-1:0] lk_link_encoding_error,
   input wire logic [NP-1:0] lk_buffer_overflow,
   input wire logic [NP-1:0] lk_line_total_changed,
   // asynchronous status levels, one per port
   input wire logic [NP-1:0] camera_if_error,
   input wire logic [NP-1:0] frequency_settled,
   input wire logic [NP-1:0] link_clock_absent,
   // forward-channel status, link_clk domain
   input wire logic [NP-1:0] lk_status_load,
   input wire logic [NP*8-1:0] lk_frequency_integer_mhz,
   input wire logic [NP*8-1:0] lk_frequency_fraction_mhz,
   input wire logic [NP*6-1:0] lk_remote_alarms,
   input wire logic [NP*3-1:0] lk_remote_voltage_one_sample,
   input wire logic [NP*3-1:0] lk_remote_voltage_zero_sample,
   input wire logic [NP*3-1:0] lk_remote_temperature
);
   logic [SELW-1:0] sel_ff;
   logic [rps_pkg::EV_W-1:0] sticky_ff [NP];
   logic [rps_pkg::EV_W-1:0] ev_core [NP];
   logic [2:0] lvl_meta_ff [NP];
   logic [2:0] lvl_ff [NP];
   logic [rps_pkg::FW_W-1:0] fwd_ff [NP];
   logic [rps_pkg::FW_W-1:0] fwd_new [NP];
   logic [NP-1:0] fwd_valid;
   logic [7:0] rdata_ff;
   logic [7:0] rd_val;
   logic [7:0] sts_sel;
   logic [rps_pkg::FW_W-1:0] fwd_sel;
   logic rd_sts;

   assign rd_sts = reg_rd && (reg_addr == rps_pkg::ADDR_STATUS_TWO);

   // per-port crossings: five event pulses and one forwarded word
   generate
      for (genvar p = 0; p < NP; p++)
      begin : g_port
         logic [rps_pkg::EV_W-1:0] lk_ev;
         logic [rps_pkg::FW_W-1:0] lk_word;
         assign lk_ev[rps_pkg::EV_LEN_UNSTEADY] = lk_line_length_unsteady[p];
         assign lk_ev[rps_pkg::EV_LEN_CHANGED] = lk_line_length_changed[p];
         assign lk_ev[rps_pkg::EV_ENCODE_ERR] = lk_link_encoding_error[p];
         assign lk_ev[rps_pkg::EV_BUFFER_ERR] = lk_buffer_overflow[p];
         assign lk_ev[rps_pkg::EV_LINE_TOTAL] = lk_line_total_changed[p];
         // one forwarded word per port keeps frequency and sensor fields coherent
         assign lk_word = {lk_remote_temperature[p*3 +: 3],
                           lk_remote_voltage_one_sample[p*3 +: 3],
                           lk_remote_voltage_zero_sample[p*3 +: 3],
                           lk_remote_alarms[p*6 +: 6],
                           lk_frequency_integer_mhz[p*8 +: 8],
                           lk_frequency_fraction_mhz[p*8 +: 8]};
         for (genvar e = 0; e < rps_pkg::EV_W; e++)
         begin : g_evt
            rps_evt_sync u_evt
            (
               .src_clk(link_clk),
               .dst_clk(clk),
               .rst_n(rst_n),
               .src_pulse(lk_ev[e]),
               .dst_pulse(ev_core[p][e])
            );
         end
         // sensor status arrives with no software action
         rps_word_sync #(.W(rps_pkg::FW_W)) u_word
         (
            .src_clk(link_clk),
            .dst_clk(clk),
            .rst_n(rst_n),
            .src_load(lk_status_load[p]),
            .src_data(lk_word),
            .dst_valid(fwd_valid[p]),
            .dst_data(fwd_new[p])
         );
      end
   endgenerate

   // port select: out-of-range values are ignored so a port always answers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sel_ff <= '0;
      else if (reg_wr && (reg_addr == rps_pkg::ADDR_PORT_SEL) && (reg_wdata < NP))
         sel_ff <= reg_wdata[SELW-1:0];
   end

   // sticky flags: the clearing read only hits the selected port, a new event wins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NP; p++)
            sticky_ff[p] <= '0;
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (rd_sts && (sel_ff == p[SELW-1:0]))
               sticky_ff[p] <= ev_core[p];
            else
               sticky_ff[p] <= sticky_ff[p] | ev_core[p];
         end
      end
   end

   // status levels come from outside this clock, so two flops first
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NP; p++)
         begin
            lvl_meta_ff[p] <= '0;
            lvl_ff[p] <= '0;
         end
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            lvl_meta_ff[p] <= {camera_if_error[p], frequency_settled[p], link_clock_absent[p]};
            lvl_ff[p] <= lvl_meta_ff[p];
         end
      end
   end

   // forwarded words replace the held copy whole
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NP; p++)
            fwd_ff[p] <= rps_pkg::FWD_RST;
      end
      else
      begin
         for (int p = 0; p < NP; p++)
            if (fwd_valid[p])
               fwd_ff[p] <= fwd_new[p];
      end
   end

   // selected port's status byte
   always_comb
   begin
      sts_sel = rps_pkg::STATUS_RST;
      sts_sel[rps_pkg::BIT_LEN_UNSTEADY] = sticky_ff[sel_ff][rps_pkg::EV_LEN_UNSTEADY];
      sts_sel[rps_pkg::BIT_LEN_CHANGED] = sticky_ff[sel_ff][rps_pkg::EV_LEN_CHANGED];
      sts_sel[rps_pkg::BIT_ENCODE_ERR] = sticky_ff[sel_ff][rps_pkg::EV_ENCODE_ERR];
      sts_sel[rps_pkg::BIT_BUFFER_ERR] = sticky_ff[sel_ff][rps_pkg::EV_BUFFER_ERR];
      sts_sel[rps_pkg::BIT_CAMERA_ERR] = lvl_ff[sel_ff][2];
      sts_sel[rps_pkg::BIT_FREQ_SETTLED] = lvl_ff[sel_ff][1];
      sts_sel[rps_pkg::BIT_CLK_ABSENT] = lvl_ff[sel_ff][0];
      sts_sel[rps_pkg::BIT_LINE_TOTAL] = sticky_ff[sel_ff][rps_pkg::EV_LINE_TOTAL];
   end

   assign fwd_sel = fwd_ff[sel_ff];

   // read decode; unmapped offsets read zero, reserved bits read zero
   always_comb
   begin
      rd_val = 8'h00;
      if (reg_addr == rps_pkg::ADDR_PORT_SEL)
         rd_val[SELW-1:0] = sel_ff;
      else if (reg_addr == rps_pkg::ADDR_STATUS_TWO)
         rd_val = sts_sel;
      else if (reg_addr == rps_pkg::ADDR_FREQ_INT)
         rd_val = fwd_sel[rps_pkg::FW_INT_LSB +: 8];
      else if (reg_addr == rps_pkg::ADDR_FREQ_FRAC)
         rd_val = fwd_sel[rps_pkg::FW_FRAC_LSB +: 8];
      else if (reg_addr == rps_pkg::ADDR_ALARMS)
         rd_val[5:0] = fwd_sel[rps_pkg::FW_ALARM_LSB +: 6];
      else if (reg_addr == rps_pkg::ADDR_VOLTS)
      begin
         rd_val[rps_pkg::VONE_POS +: 3] = fwd_sel[rps_pkg::FW_VONE_LSB +: 3];
         rd_val[rps_pkg::VZERO_POS +: 3] = fwd_sel[rps_pkg::FW_VZERO_LSB +: 3];
      end
      else if (reg_addr == rps_pkg::ADDR_TEMP)
         rd_val[2:0] = fwd_sel[rps_pkg::FW_TEMP_LSB +: 3];
   end

   // read data is captured on the read strobe and held until the next read
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= 8'h00;
      else if (reg_rd)
         rdata_ff <= rd_val;
   end

   assign reg_rdata = rdata_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_sel_write;
      reg_wr && (reg_addr == rps_pkg::ADDR_PORT_SEL) && (reg_wdata < NP)
         |=> sel_ff == $past(reg_wdata[SELW-1:0]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("port select not updated");

   property p_sts_read;
      rd_sts |=> reg_rdata == $past(sts_sel);
   endproperty
   a_sts_read: assert property (p_sts_read) else $error("status read wrong");

   property p_unsteady_hold;
      sticky_ff[sel_ff][rps_pkg::EV_LEN_UNSTEADY] && !reg_rd && !reg_wr
         |=> sticky_ff[sel_ff][rps_pkg::EV_LEN_UNSTEADY];
   endproperty
   a_unsteady_hold: assert property (p_unsteady_hold) else $error("unsteady flag lost");

   property p_clear_on_read;
      rd_sts && !ev_core[sel_ff][rps_pkg::EV_LEN_CHANGED] && !reg_wr
         |=> !sticky_ff[sel_ff][rps_pkg::EV_LEN_CHANGED];
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("flag not cleared");

   property p_set_wins;
      rd_sts && ev_core[sel_ff][rps_pkg::EV_ENCODE_ERR] && !reg_wr
         |=> sticky_ff[sel_ff][rps_pkg::EV_ENCODE_ERR];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   property p_event_sets;
      !reg_wr && ev_core[sel_ff][rps_pkg::EV_BUFFER_ERR]
         |=> sticky_ff[sel_ff][rps_pkg::EV_BUFFER_ERR] ##1
             (sticky_ff[sel_ff][rps_pkg::EV_BUFFER_ERR] || $past(rd_sts) || $past(reg_wr));
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("buffer flag not set");

   property p_camera_level;
      rd_sts |=> reg_rdata[rps_pkg::BIT_CAMERA_ERR] == $past(lvl_ff[sel_ff][2]);
   endproperty
   a_camera_level: assert property (p_camera_level) else $error("camera bit wrong");

   property p_alarm_reserved;
      reg_rd && (reg_addr == rps_pkg::ADDR_ALARMS) |=> reg_rdata[7:6] == 2'h0;
   endproperty
   a_alarm_reserved: assert property (p_alarm_reserved) else $error("alarm reserved set");

   property p_volt_reserved;
      reg_rd && (reg_addr == rps_pkg::ADDR_VOLTS) |=> !reg_rdata[7] && !reg_rdata[3];
   endproperty
   a_volt_reserved: assert property (p_volt_reserved) else $error("volt reserved set");

   property p_temp_read;
      reg_rd && (reg_addr == rps_pkg::ADDR_TEMP)
         |=> reg_rdata == {5'h00, $past(fwd_sel[rps_pkg::FW_TEMP_LSB +: 3])};
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("temperature read wrong");

   property p_fwd_load;
      fwd_valid[sel_ff] && !reg_wr |=> fwd_sel == $past(fwd_new[sel_ff]);
   endproperty
   a_fwd_load: assert property (p_fwd_load) else $error("forward word not loaded");

   property p_sel_refused;
      reg_wr && (reg_addr == rps_pkg::ADDR_PORT_SEL) && (reg_wdata >= NP) |=> $stable(sel_ff);
   endproperty
   a_sel_refused: assert property (p_sel_refused) else $error("bad select taken");

   property p_unsteady_clear;
      rd_sts && !ev_core[sel_ff][rps_pkg::EV_LEN_UNSTEADY] && !reg_wr
         |=> !sticky_ff[sel_ff][rps_pkg::EV_LEN_UNSTEADY];
   endproperty
   a_unsteady_clear: assert property (p_unsteady_clear) else $error("unsteady kept");

   property p_encode_sets;
      ev_core[sel_ff][rps_pkg::EV_ENCODE_ERR] && !reg_wr
         |=> sticky_ff[sel_ff][rps_pkg::EV_ENCODE_ERR];
   endproperty
   a_encode_sets: assert property (p_encode_sets) else $error("encode flag not set");

   property p_total_clear;
      rd_sts && !ev_core[sel_ff][rps_pkg::EV_LINE_TOTAL] && !reg_wr
         |=> !sticky_ff[sel_ff][rps_pkg::EV_LINE_TOTAL];
   endproperty
   a_total_clear: assert property (p_total_clear) else $error("line total kept");

   property p_level_bits;
      rd_sts |=> reg_rdata[rps_pkg::BIT_FREQ_SETTLED] == $past(lvl_ff[sel_ff][1])
         && reg_rdata[rps_pkg::BIT_CLK_ABSENT] == $past(lvl_ff[sel_ff][0]);
   endproperty
   a_level_bits: assert property (p_level_bits) else $error("level bits wrong");

   property p_freq_read;
      reg_rd && (reg_addr == rps_pkg::ADDR_FREQ_INT)
         |=> reg_rdata == $past(fwd_sel[rps_pkg::FW_INT_LSB +: 8]);
   endproperty
   a_freq_read: assert property (p_freq_read) else $error("frequency integer wrong");

   property p_frac_read;
      reg_rd && (reg_addr == rps_pkg::ADDR_FREQ_FRAC)
         |=> reg_rdata == $past(fwd_sel[rps_pkg::FW_FRAC_LSB +: 8]);
   endproperty
   a_frac_read: assert property (p_frac_read) else $error("frequency fraction wrong");

   property p_alarm_read;
      reg_rd && (reg_addr == rps_pkg::ADDR_ALARMS)
         |=> reg_rdata[5:0] == $past(fwd_sel[rps_pkg::FW_ALARM_LSB +: 6]);
   endproperty
   a_alarm_read: assert property (p_alarm_read) else $error("alarm flags wrong");

   property p_volt_read;
      reg_rd && (reg_addr == rps_pkg::ADDR_VOLTS)
         |=> reg_rdata[6:4] == $past(fwd_sel[rps_pkg::FW_VONE_LSB +: 3])
             && reg_rdata[2:0] == $past(fwd_sel[rps_pkg::FW_VZERO_LSB +: 3]);
   endproperty
   a_volt_read: assert property (p_volt_read) else $error("voltage samples wrong");
endmodule // rps_status_bank

// file: core/rps_pkg.sv
// constants shared by the receive-port status bank
package rps_pkg;
   // register offsets on the control port
   localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
   localparam logic [7:0] ADDR_STATUS_TWO = 8'h4E;
   localparam logic [7:0] ADDR_FREQ_INT = 8'h4F;
   localparam logic [7:0] ADDR_FREQ_FRAC = 8'h50;
   localparam logic [7:0] ADDR_ALARMS = 8'h51;
   localparam logic [7:0] ADDR_VOLTS = 8'h52;
   localparam logic [7:0] ADDR_TEMP = 8'h53;
   // bit positions in rx_port_status_two
   localparam int BIT_LEN_UNSTEADY = 7;
   localparam int BIT_LEN_CHANGED = 6;
   localparam int BIT_ENCODE_ERR = 5;
   localparam int BIT_BUFFER_ERR = 4;
   localparam int BIT_CAMERA_ERR = 3;
   localparam int BIT_FREQ_SETTLED = 2;
   localparam int BIT_CLK_ABSENT = 1;
   localparam int BIT_LINE_TOTAL = 0;
   // index of each sticky event inside a port's event vector
   localparam int EV_LEN_UNSTEADY = 4;
   localparam int EV_LEN_CHANGED = 3;
   localparam int EV_ENCODE_ERR = 2;
   localparam int EV_BUFFER_ERR = 1;
   localparam int EV_LINE_TOTAL = 0;
   localparam int EV_W = 5;
   // layout of the forwarded status word
   localparam int FW_FRAC_LSB = 0;
   localparam int FW_INT_LSB = 8;
   localparam int FW_ALARM_LSB = 16;
   localparam int FW_VZERO_LSB = 22;
   localparam int FW_VONE_LSB = 25;
   localparam int FW_TEMP_LSB = 28;
   localparam int FW_W = 31;
   // field positions inside the sensor registers
   localparam int VONE_POS = 4;
   localparam int VZERO_POS = 0;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [FW_W-1:0] FWD_RST = 31'h0;
endpackage : rps_pkg

// file: core/rps_evt_sync.sv
// toggle crossing that carries one-cycle event pulses between clocks
`timescale 1ns/10ps
module rps_evt_sync
(
   // clocks and reset
   input wire logic src_clk,
   input wire logic dst_clk,
   input wire logic rst_n,
   // event in, source domain
   input wire logic src_pulse,
   // event out, destination domain
   output logic dst_pulse
);
   logic tog_ff;
   logic meta_ff;
   logic sync_ff;
   logic seen_ff;

   // each event flips the toggle, so back-to-back source pulses are not merged
   always_ff @(posedge src_clk or negedge rst_n)
   begin
      if (!rst_n)
         tog_ff <= 1'b0;
      else if (src_pulse)
         tog_ff <= ~tog_ff;
   end

   // two-stage synchroniser, then edge detect on the settled stage only
   always_ff @(posedge dst_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         seen_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= tog_ff;
         sync_ff <= meta_ff;
         seen_ff <= sync_ff;
      end
   end

   assign dst_pulse = sync_ff ^ seen_ff;
endmodule // rps_evt_sync

// file: core/rps_word_sync.sv
// request/acknowledge crossing for a word; the newest source word wins
`timescale 1ns/10ps
module rps_word_sync
#(
   parameter int W = 8
)
(
   // clocks and reset
   input wire logic src_clk,
   input wire logic dst_clk,
   input wire logic rst_n,
   // source side
   input wire logic src_load,
   input wire logic [W-1:0] src_data,
   // destination side
   output logic dst_valid,
   output logic [W-1:0] dst_data
);
   logic [W-1:0] latest_ff;
   logic [W-1:0] hold_ff;
   logic pend_ff;
   logic req_ff;
   logic ack_meta_ff;
   logic ack_ff;
   logic req_meta_ff;
   logic req_sync_ff;
   logic req_seen_ff;
   logic [W-1:0] out_ff;
   logic valid_ff;
   logic idle;

   assign idle = (req_ff == ack_ff);

   // hold_ff stays frozen while a request is in flight
   always_ff @(posedge src_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latest_ff <= '0;
         hold_ff <= '0;
         pend_ff <= 1'b0;
         req_ff <= 1'b0;
         ack_meta_ff <= 1'b0;
         ack_ff <= 1'b0;
      end
      else
      begin
         ack_meta_ff <= req_seen_ff;
         ack_ff <= ack_meta_ff;
         if (src_load)
            latest_ff <= src_data;
         if (idle && (pend_ff || src_load))
         begin
            hold_ff <= src_load ? src_data : latest_ff;
            req_ff <= ~req_ff;
            pend_ff <= 1'b0;
         end
         else if (src_load)
            pend_ff <= 1'b1;
      end
   end

   // destination copies the frozen word once the request has settled
   always_ff @(posedge dst_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
         req_seen_ff <= 1'b0;
         out_ff <= '0;
         valid_ff <= 1'b0;
      end
      else
      begin
         req_meta_ff <= req_ff;
         req_sync_ff <= req_meta_ff;
         req_seen_ff <= req_sync_ff;
         // valid is registered so it flags the copied word, not the cycle before it
         valid_ff <= (req_sync_ff != req_seen_ff);
         if (req_sync_ff != req_seen_ff)
            out_ff <= hold_ff;
      end
   end

   assign dst_valid = valid_ff;
   assign dst_data = out_ff;
endmodule // rps_word_sync

// file: testbench/rps_link_model.sv
// behavioural remote serializer feeding link events and forwarded status words
`timescale 1ns/10ps
module rps_link_model
#(
   parameter int NP = 4
)
(
   // link clock and reset
   input wire logic link_clk,
   input wire logic rst_n,
   // receiver event pulses
   output logic [NP-1:0] lk_line_length_unsteady,
   output logic [NP-1:0] lk_line_length_changed,
   output logic [NP-1:0] lk_link_encoding_error,
   output logic [NP-1:0] lk_buffer_overflow,
   output logic [NP-1:0] lk_line_total_changed,
   // forwarded status word
   output logic [NP-1:0] lk_status_load,
   output logic [NP*8-1:0] lk_frequency_integer_mhz,
   output logic [NP*8-1:0] lk_frequency_fraction_mhz,
   output logic [NP*6-1:0] lk_remote_alarms,
   output logic [NP*3-1:0] lk_remote_voltage_one_sample,
   output logic [NP*3-1:0] lk_remote_voltage_zero_sample,
   output logic [NP*3-1:0] lk_remote_temperature
);
   logic [NP-1:0] ev_ff [5];

   // event index follows the bank's sticky event order
   assign lk_line_total_changed = ev_ff[0];
   assign lk_buffer_overflow = ev_ff[1];
   assign lk_link_encoding_error = ev_ff[2];
   assign lk_line_length_changed = ev_ff[3];
   assign lk_line_length_unsteady = ev_ff[4];

   // quiet link at time zero, data lines hold a non-zero pattern
   initial
   begin
      for (int k = 0; k < 5; k++) ev_ff[k] = '0;
      lk_status_load = '0;
      lk_frequency_integer_mhz = {NP{8'hA5}};
      lk_frequency_fraction_mhz = {NP{8'h5A}};
      lk_remote_alarms = {NP{6'h2A}};
      lk_remote_voltage_one_sample = {NP{3'h5}};
      lk_remote_voltage_zero_sample = {NP{3'h2}};
      lk_remote_temperature = {NP{3'h6}};
   end

   // one link cycle pulse on each selected kind
   task automatic fire_event(input int p, input logic [4:0] kinds);
      @(posedge link_clk iff rst_n);
      for (int k = 0; k < 5; k++) if (kinds[k]) ev_ff[k][p] <= 1'b1;
      @(posedge link_clk);
      for (int k = 0; k < 5; k++) ev_ff[k] <= '0;
   endtask

   // one forwarded word; afterwards the data lines invert so stale data never matches
   task automatic load_word(input int p, input logic [30:0] w);
      @(posedge link_clk iff rst_n);
      lk_status_load[p] <= 1'b1;
      lk_frequency_fraction_mhz[p*8+:8] <= w[7:0];
      lk_frequency_integer_mhz[p*8+:8] <= w[15:8];
      lk_remote_alarms[p*6+:6] <= w[21:16];
      lk_remote_voltage_zero_sample[p*3+:3] <= w[24:22];
      lk_remote_voltage_one_sample[p*3+:3] <= w[27:25];
      lk_remote_temperature[p*3+:3] <= w[30:28];
      @(posedge link_clk);
      lk_status_load <= '0;
      lk_frequency_fraction_mhz <= ~lk_frequency_fraction_mhz;
      lk_frequency_integer_mhz <= ~lk_frequency_integer_mhz;
      lk_remote_alarms <= ~lk_remote_alarms;
      lk_remote_voltage_zero_sample <= ~lk_remote_voltage_zero_sample;
      lk_remote_voltage_one_sample <= ~lk_remote_voltage_one_sample;
      lk_remote_temperature <= ~lk_remote_temperature;
   endtask
endmodule // rps_link_model

// file: testbench/rps_status_bank_bench.sv
// self-checking bench for the receive-port status bank
`timescale 1ns/10ps
module rps_status_bank_bench;
   localparam int NP = 4;
   localparam int EVBIT [5] = '{0, 4, 5, 6, 7};
   logic clk, link_clk, rst_n, reg_wr, reg_rd, rd_seen_ff, burst_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, a;
   logic [NP-1:0] cam_err, freq_ok, clk_gone, ev_unst, ev_chg, ev_enc, ev_buf, ev_tot, ld;
   logic [NP*8-1:0] f_int, f_frac;
   logic [NP*6-1:0] alarms;
   logic [NP*3-1:0] v_one, v_zero, temp;
   logic [30:0] w;
   logic [7:0] exp_q [$];
   string name_q [$];
   int err_total = 0;
   int comparisons = 0;
   int hit_cnt = 0;

   // core clock 100 MHz
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // link clock 80 ns, offset so the edges never line up
   initial
   begin
      link_clk = 1'b0;
      #17;
      forever #40 link_clk = ~link_clk;
   end

   rps_status_bank #(.NP(NP), .SELW(2)) rps_status_bank_i (
      .clk(clk), .link_clk(link_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .lk_line_length_unsteady(ev_unst), .lk_line_length_changed(ev_chg),
      .lk_link_encoding_error(ev_enc), .lk_buffer_overflow(ev_buf),
      .lk_line_total_changed(ev_tot), .camera_if_error(cam_err),
      .frequency_settled(freq_ok), .link_clock_absent(clk_gone), .lk_status_load(ld),
      .lk_frequency_integer_mhz(f_int), .lk_frequency_fraction_mhz(f_frac),
      .lk_remote_alarms(alarms), .lk_remote_voltage_one_sample(v_one),
      .lk_remote_voltage_zero_sample(v_zero), .lk_remote_temperature(temp));

   rps_link_model #(.NP(NP)) rps_link_model_i (
      .link_clk(link_clk), .rst_n(rst_n),
      .lk_line_length_unsteady(ev_unst), .lk_line_length_changed(ev_chg),
      .lk_link_encoding_error(ev_enc), .lk_buffer_overflow(ev_buf),
      .lk_line_total_changed(ev_tot), .lk_status_load(ld),
      .lk_frequency_integer_mhz(f_int), .lk_frequency_fraction_mhz(f_frac),
      .lk_remote_alarms(alarms), .lk_remote_voltage_one_sample(v_one),
      .lk_remote_voltage_zero_sample(v_zero), .lk_remote_temperature(temp));

   task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // strobes drop on the following edge, so back-to-back calls never collide
   task automatic reg_write(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] ad, input logic [7:0] e, input string n);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      exp_q.push_back(e);
      name_q.push_back(n);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   // level bits that a read of the status register must show for port p
   function automatic logic [7:0] lvl(input int p);
      lvl = {4'h0, cam_err[p], freq_ok[p], clk_gone[p], 1'b0};
   endfunction

   // read data is due the cycle after the strobe is taken
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_seen_ff <= 1'b0;
      else
         rd_seen_ff <= reg_rd;
   end

   // compare each answer outside a burst with the oldest note; burst answers only count the encode bit
   always @(negedge clk)
   begin
      if (rd_seen_ff && burst_on)
         hit_cnt += reg_rdata[rps_pkg::BIT_ENCODE_ERR];
      else if (rd_seen_ff)
      begin
         if (exp_q.size() == 0)
         begin
            err_total++;
            $display("ERROR read data expected none seen %h", reg_rdata);
         end
         else
            check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
      end
   end

   // a hang is cut short here
   initial
   begin
      repeat (50000) @(posedge clk);
      err_total++;
      $display("ERROR timeout expected end seen hang");
      report_and_stop();
   end

   // main sequence
   initial
   begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, burst_on, reg_addr, reg_wdata} = '0;
      {cam_err, freq_ok, clk_gone} = '0;
      void'($urandom(42));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge link_clk);
      // reset values, the neighbour offset 0x4D and far offsets read zero
      for (a = 8'h4C; a <= 8'h53; a++) reg_read(a, 8'h00, "reset value");
      reg_read(8'hFF, 8'h00, "unmapped");
      reg_write(rps_pkg::ADDR_FREQ_INT, 8'hFF);
      reg_read(rps_pkg::ADDR_FREQ_INT, 8'h00, "read-only");
      // every port selectable; out-of-range select refused
      for (int p = 0; p < NP; p++)
      begin
         reg_write(rps_pkg::ADDR_PORT_SEL, 8'(p));
         reg_read(rps_pkg::ADDR_PORT_SEL, 8'(p), "port select");
      end
      reg_write(rps_pkg::ADDR_PORT_SEL, 8'h04);
      reg_read(rps_pkg::ADDR_PORT_SEL, 8'h03, "select refused");
      // each sticky kind on each port; the other port must not see it or clear it
      for (int p = 0; p < NP; p++)
         for (int k = 0; k < 6; k++)
         begin
            rps_link_model_i.fire_event(p, (k == 5) ? 5'h1F : 5'(1 << k));
            repeat (8) @(posedge clk);
            reg_write(rps_pkg::ADDR_PORT_SEL, 8'((p + 1) % NP));
            reg_read(rps_pkg::ADDR_STATUS_TWO, lvl((p + 1) % NP), "other port");
            reg_write(rps_pkg::ADDR_PORT_SEL, 8'(p));
            reg_read(rps_pkg::ADDR_STATUS_TWO,
               lvl(p) | ((k == 5) ? 8'hF1 : 8'(1 << EVBIT[k])), "event flag");
            reg_read(rps_pkg::ADDR_STATUS_TWO, lvl(p), "cleared on read");
         end
      // a read on every cycle forces the event into a clearing read; it must show once
      reg_write(rps_pkg::ADDR_PORT_SEL, 8'h01);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= rps_pkg::ADDR_STATUS_TWO;
      burst_on <= 1'b1;
      rps_link_model_i.fire_event(1, 5'h04);
      repeat (8) @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      burst_on <= 1'b0;
      check("set wins", 8'(hit_cnt), 8'h01);
      reg_read(rps_pkg::ADDR_STATUS_TWO, lvl(1), "no flag left");
      // random levels show on every port and survive reads
      @(posedge clk);
      cam_err <= NP'($urandom());
      freq_ok <= NP'($urandom());
      clk_gone <= NP'($urandom());
      repeat (4) @(posedge clk);
      for (int p = 0; p < NP; p++)
      begin
         reg_write(rps_pkg::ADDR_PORT_SEL, 8'(p));
         reg_read(rps_pkg::ADDR_STATUS_TWO, lvl(p), "level bits");
         reg_read(rps_pkg::ADDR_STATUS_TWO, lvl(p), "level kept");
      end
      // forwarded words land in the selected port's sensor registers
      for (int p = 0; p < NP; p++)
      begin
         reg_write(rps_pkg::ADDR_PORT_SEL, 8'(p));
         w = 31'($urandom());
         rps_link_model_i.load_word(p, w);
         repeat (2) @(posedge link_clk);
         repeat (6) @(posedge clk);
         reg_read(rps_pkg::ADDR_FREQ_INT, w[15:8], "frequency integer");
         reg_read(rps_pkg::ADDR_FREQ_FRAC, w[7:0], "frequency fraction");
         reg_read(rps_pkg::ADDR_ALARMS, {2'b00, w[21:16]}, "alarms");
         reg_read(rps_pkg::ADDR_VOLTS, {1'b0, w[27:25], 1'b0, w[24:22]}, "volts");
         reg_read(rps_pkg::ADDR_TEMP, {5'h00, w[30:28]}, "temperature");
      end
      // reset in mid-run returns select and forwarded values to zero
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge link_clk);
      reg_read(rps_pkg::ADDR_PORT_SEL, 8'h00, "select after reset");
      reg_read(rps_pkg::ADDR_FREQ_INT, 8'h00, "frequency after reset");
      reg_read(rps_pkg::ADDR_STATUS_TWO, lvl(0), "status after reset");
      repeat (3) @(posedge clk);
      report_and_stop();
   end
endmodule // rps_status_bank_bench
